// *** mcu_control_pkg.sv ***
// constants for the mcu control register block
package mcu_control_pkg;
  localparam logic [7:0] data_offset       = 8'h55;  // data-space address
  localparam logic [7:0] io_space_base     = 8'h20;  // io address = data address - this
  localparam logic [5:0] io_offset         = 6'h35;  // io-space address
  localparam logic [7:0] reg_reset         = 8'h00;
  localparam int         bit_bod_off       = 6;
  localparam int         bit_bod_unlock    = 5;
  localparam int         bit_pullup_off    = 4;
  localparam int         bit_vec_select    = 1;
  localparam int         bit_vec_unlock    = 0;
  localparam logic [7:0] implemented_mask  = 8'h73;
  localparam int         unlock_cycles     = 4;      // timed window length
  localparam int         bod_delay_cycles  = 3;      // sleep-off delay and lifetime
  localparam int         vector_words      = 2;      // words per vector entry
  localparam logic [2:0] count_zero        = 3'h0;
  localparam logic [2:0] unlock_count_init = 3'h4;
  localparam logic [2:0] bod_count_init    = 3'h3;
  localparam logic [1:0] pullup_pattern    = 2'h1;   // {direction, output} = 0b01
endpackage

// *** timed_window.sv ***
`timescale 1ns/10ps
// down counter that keeps a window open for a fixed number of cycles
module timed_window
  import mcu_control_pkg::*;
#(
  parameter logic [2:0] length = 3'h4
) (
  input  wire logic ref_clk,  // system clock
  input  wire logic rstn,     // async reset, active low
  input  wire logic start,    // open the window
  input  wire logic stop,     // close early
  output logic      open_q    // window open
);
  logic [2:0] count_q;

  // stop wins over expiry, start restarts the count
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= count_zero;
    end else if (start) begin
      count_q <= length;
    end else if (stop) begin
      count_q <= count_zero;
    end else if (count_q != count_zero) begin
      count_q <= count_q - 3'h1;
    end
  end

  assign open_q = (count_q != count_zero);
endmodule

// *** mcu_control.sv ***
`timescale 1ns/10ps
// mcu control register: vector placement, brown-out sleep-off, pull-up disable
// Summary of operation
// - select zero fetches vectors from flash start, one from boot section start
// - relocated base equals boot section start from the boot size fuses
// - select changes need unlock write then select write within four cycles
// - interrupts blocked from unlock until after instruction after select write
// - without a select write, blocking lasts five cycles after the unlock write then ends
// - automatic blocking never touches the global interrupt enable bit
// - unlock bit clears after four cycles or on select write
// - boot vectors with app lock bit block interrupts while in application
// - app vectors with boot lock bit block interrupts while in boot section
// - sleep-off needs both bits set, then sleep-off alone within four cycles
// - sleep-off active three cycles after set, cleared after three more
// - detector turns off only if sleep executes while sleep-off active
// - global pull-up off disables every pull-up, pattern 0b01 included
// - decode at data address 0x55 and io address 0x35
// - bits 6,5,4,1,0 implemented; 7,3,2 read zero; reset zero
// - each vector entry spans two instruction words
module mcu_control
  import mcu_control_pkg::*;
#(
  parameter int addr_width = 14,   // program word address width
  parameter int vec_width  = 6,    // vector number width
  parameter int pins       = 8     // port pins served by the pull-up gate
) (
  input  wire logic                  ref_clk,         // system clock
  input  wire logic                  rstn,            // async reset, active low
  input  wire logic                  data_we,         // data-space write strobe
  input  wire logic                  io_we,           // io-space write strobe
  input  wire logic [7:0]            data_addr,       // data-space address
  input  wire logic [5:0]            io_addr,         // io-space address
  input  wire logic [7:0]            wdata,           // write data
  output logic      [7:0]            rdata,           // register read data
  input  wire logic                  instr_done,      // core retired an instruction
  input  wire logic                  sleep_exec,      // sleep instruction executing
  input  wire logic [addr_width-1:0] boot_start,      // boot start from boot_size_fuses
  input  wire logic                  app_section_lock_bit,   // application lock programmed
  input  wire logic                  boot_section_lock_bit,  // boot lock programmed
  input  wire logic                  exec_in_boot,    // core fetching from boot section
  input  wire logic [vec_width-1:0]  vec_number,      // vector being taken
  input  wire logic [pins-1:0]       pin_direction_bit,  // direction bits
  input  wire logic [pins-1:0]       pin_output_bit,     // output bits
  output logic                       irq_block,       // interrupts must not be taken
  output logic [addr_width-1:0]      vector_addr,     // program address of vector
  output logic                       brownout_off,    // detector off for this sleep
  output logic [pins-1:0]            pullup_en,       // per-pin pull-up enable
  output logic                       vector_table_select,  // current select bit
  output logic                       pullup_global_off     // current pull-up off bit
);

  // ---- address decode and write view ----
  logic       hit_w;
  logic       vec_unlock_wr;
  logic       vec_select_wr;
  logic       bod_unlock_wr;
  logic       bod_set_wr;
  logic       vec_open;
  logic       bod_open;
  logic [2:0] bod_count_q;
  logic       bod_pending_q;
  logic       select_seen_q;
  logic       bod_unlock_q;
  logic       unlock_bit;

  assign hit_w = (data_we && data_addr == data_offset) ||
                 (io_we && io_addr == io_offset);

  // unlock write sets the vector unlock bit
  assign vec_unlock_wr = hit_w && wdata[bit_vec_unlock];
  // select write counts only inside the open window with unlock zero
  assign vec_select_wr = hit_w && !wdata[bit_vec_unlock] && vec_open;
  // first step: both sleep-off and unlock written one
  assign bod_unlock_wr = hit_w && wdata[bit_bod_off] && wdata[bit_bod_unlock];
  // second step only honoured inside the open window
  assign bod_set_wr    = hit_w && wdata[bit_bod_off] && !wdata[bit_bod_unlock] && bod_open;

  // vector unlock window, four cycles or closed by select write
  timed_window #(.length(unlock_count_init)) vec_window (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (vec_unlock_wr),
    .stop    (vec_select_wr),
    .open_q  (vec_open)
  );

  // brown-out unlock window of four cycles
  timed_window #(.length(unlock_count_init)) bod_window (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .start   (bod_unlock_wr),
    .stop    (bod_set_wr),
    .open_q  (bod_open)
  );

  assign unlock_bit = vec_open;

  // ---- stored control bits ----
  // implemented bits reset to zero
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      vector_table_select <= 1'b0;
      pullup_global_off   <= 1'b0;
    end else if (hit_w) begin
      pullup_global_off <= wdata[bit_pullup_off];
      if (vec_select_wr) begin
        vector_table_select <= wdata[bit_vec_select];
      end
    end
  end

  // brown-out unlock bit mirrors its window for read-back
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bod_unlock_q <= 1'b0;
    end else begin
      bod_unlock_q <= bod_open && !bod_set_wr;
    end
  end

  // ---- brown-out sleep-off timing ----
  // three-cycle delay, then three active cycles, then auto-clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bod_count_q   <= count_zero;
      bod_pending_q <= 1'b0;
    end else if (bod_set_wr) begin
      bod_count_q   <= bod_count_init;
      bod_pending_q <= 1'b1;
    end else if (bod_pending_q && bod_count_q == 3'h1) begin
      bod_count_q   <= bod_count_init;  // reload on the last quiet cycle, no idle gap
      bod_pending_q <= 1'b0;
    end else if (bod_count_q != count_zero) begin
      bod_count_q <= bod_count_q - 3'h1;
    end
  end

  logic bod_active;
  assign bod_active = !bod_pending_q && (bod_count_q != count_zero);

  // detector off only for a sleep in the active window
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      brownout_off <= 1'b0;
    end else if (sleep_exec) begin
      brownout_off <= bod_active;
    end else if (instr_done) begin
      brownout_off <= 1'b0;
    end
  end

  // ---- interrupt blocking ----
  // hold past the instruction that follows the select write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      select_seen_q <= 1'b0;
    end else if (vec_select_wr) begin
      select_seen_q <= 1'b1;
    end else if (instr_done) begin
      select_seen_q <= 1'b0;
    end
  end

  logic lock_block;
  // boot vectors plus app lock, running from application
  // app vectors plus boot lock, running from boot section
  assign lock_block = (vector_table_select && app_section_lock_bit && !exec_in_boot) ||
                      (!vector_table_select && boot_section_lock_bit && exec_in_boot);

  // block output only; no status-register bit is written here
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_block <= 1'b0;
    end else begin
      irq_block <= vec_unlock_wr || vec_open || vec_select_wr || select_seen_q ||
                   lock_block;
    end
  end

  // ---- vector address ----
  logic [addr_width-1:0] vec_base;
  logic [addr_width-1:0] vec_step;
  // base from select bit and fuse-derived boot start
  assign vec_base = vector_table_select ? boot_start : {addr_width{1'b0}};
  assign vec_step = addr_width'({vec_number, 1'b0});

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      vector_addr <= {addr_width{1'b0}};
    end else begin
      vector_addr <= vec_base + vec_step;
    end
  end

  // ---- pull-up gating ----
  // per-pin pull-up, forced off by the global bit
  genvar g;
  generate
    for (g = 0; g < pins; g++) begin : pin_gate
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          pullup_en[g] <= 1'b0;
        end else begin
          pullup_en[g] <= !pullup_global_off &&
                          ({pin_direction_bit[g], pin_output_bit[g]} == pullup_pattern);
        end
      end
    end
  endgenerate

  // ---- read-back ----
  logic [7:0] read_w;
  assign read_w = {1'b0, bod_active, bod_unlock_q, pullup_global_off,
                   2'b00, vector_table_select, unlock_bit} & implemented_mask;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= reg_reset;
    end else begin
      rdata <= read_w;
    end
  end

  // ---- assertions ----
  // window never exceeds four cycles after unlock
  sequence unlock_then_quiet;
    vec_unlock_wr ##1 (!vec_unlock_wr)[*4];
  endsequence

  unlock_clear_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) unlock_then_quiet |=> !vec_open)
    else $error("vector unlock stayed open too long");

  select_closes_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) vec_select_wr |=> !vec_open)
    else $error("select write did not close unlock");

  select_guard_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) (hit_w && !vec_open && !wdata[bit_vec_unlock])
      |=> $stable(vector_table_select))
    else $error("select changed without unlock");

  block_start_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) vec_unlock_wr |=> irq_block)
    else $error("interrupts not blocked after unlock");

  block_hold_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) (vec_unlock_wr && !lock_block) |=> irq_block[*4])
    else $error("block shorter than four cycles");

  bod_guard_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) (hit_w && !bod_open && !wdata[bit_bod_unlock])
      |=> !bod_pending_q || $past(bod_pending_q))
    else $error("sleep-off armed without unlock");

  bod_timing_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) bod_set_wr |=> (!bod_active)[*3] ##1 bod_active[*3]
      ##1 !bod_active)
    else $error("sleep-off timing wrong");

  pullup_off_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) pullup_global_off |=> pullup_en == '0)
    else $error("pull-up enabled while globally off");

  vector_base_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) !vector_table_select && vec_number == '0
      |=> vector_addr == '0)
    else $error("vector base not at flash start");

  select_write_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) vec_select_wr |=> vector_table_select == $past(wdata[1]))
    else $error("select write did not land");

  pullup_write_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) hit_w |=> pullup_global_off == $past(wdata[4]))
    else $error("pull-up off bit not written");

  read_image_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) (rdata & ~implemented_mask) == 8'h00)
    else $error("unused bit read as one");

  brownout_gate_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) (sleep_exec && !bod_active) |=> !brownout_off)
    else $error("detector off outside sleep-off window");

  detector_clear_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) (instr_done && !sleep_exec) |=> !brownout_off)
    else $error("detector off held past sleep");

  app_lock_a : assert property (
    @(posedge ref_clk) disable iff (!rstn)
      (vector_table_select && app_section_lock_bit && !exec_in_boot) |=> irq_block)
    else $error("application code not blocked");

  boot_lock_a : assert property (
    @(posedge ref_clk) disable iff (!rstn)
      (!vector_table_select && boot_section_lock_bit && exec_in_boot) |=> irq_block)
    else $error("boot code not blocked");

  pullup_on_a : assert property (
    @(posedge ref_clk) disable iff (!rstn) !pullup_global_off
      |=> pullup_en == $past(~pin_direction_bit & pin_output_bit))
    else $error("pull-up pattern not honoured");
endmodule

// *** core_model.sv ***
// core-side model: retire and sleep strobes toward the control block
`timescale 1ns/10ps
module core_model (
  input  wire logic rstn,       // async reset, active low
  input  wire logic step,       // 1 retires every cycle, 0 stalls
  input  wire logic sleep_req,  // bench asks for a sleep
  output logic      instr_done, // retire pulse
  output logic      sleep_exec  // sleep executing
);
  // no strobes in reset; a stall holds retirement off to stretch blocking
  assign instr_done = rstn & step;
  // sleep follows the bench request, gated only by reset
  // the bench issues one sleep with sleep-off inactive and one after seeing it active
  assign sleep_exec = rstn & sleep_req;
endmodule

// *** test_mcu_control.sv ***
// self-checking bench for the mcu control register block
`timescale 1ns/10ps
module test_mcu_control import mcu_control_pkg::*; ;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        data_we = 1'b0;
  logic        io_we = 1'b0;
  logic [7:0]  data_addr = 8'h00;
  logic [5:0]  io_addr = 6'h00;
  logic [7:0]  wdata = 8'h00;
  logic        step = 1'b0;
  logic        sleep_req = 1'b0;
  logic        app_lock = 1'b0;
  logic        boot_lock = 1'b0;
  logic        in_boot = 1'b0;
  logic [5:0]  vnum = 6'h00;
  logic [7:0]  rdata, pullup_en;
  logic [13:0] vector_addr;
  logic        instr_done, sleep_exec, irq_block, brownout_off, vsel, puoff;
  int          err_total = 0;
  int          n_compared = 0;
  int          n, m, i;

  // 50 mhz system clock
  always #10 ref_clk = ~ref_clk;

  // pins 0b01 pattern: ~dir & out gives pull-ups on pins 2 and 6
  mcu_control dut_u (.ref_clk(ref_clk), .rstn(rstn), .data_we(data_we), .io_we(io_we),
    .data_addr(data_addr), .io_addr(io_addr), .wdata(wdata), .rdata(rdata),
    .instr_done(instr_done), .sleep_exec(sleep_exec), .boot_start(14'h1c00),
    .app_section_lock_bit(app_lock), .boot_section_lock_bit(boot_lock),
    .exec_in_boot(in_boot), .vec_number(vnum), .pin_direction_bit(8'h33),
    .pin_output_bit(8'h55), .irq_block(irq_block), .vector_addr(vector_addr),
    .brownout_off(brownout_off), .pullup_en(pullup_en), .vector_table_select(vsel),
    .pullup_global_off(puoff));

  core_model core_u (.rstn(rstn), .step(step), .sleep_req(sleep_req),
    .instr_done(instr_done), .sleep_exec(sleep_exec));

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask

  // one-cycle write strobe on either address space
  task automatic wr(input bit io, input logic [7:0] a, input logic [7:0] d);
    data_we = !io;
    io_we = io;
    data_addr = a;
    io_addr = a[5:0];
    wdata = d;
    cyc(1);
    data_we = 1'b0;
    io_we = 1'b0;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // a wait that ran out of cycles is a failure in its own right
  task automatic guard(input int k);
    if (k >= 20) begin
      chk("wait bound", 16'h0000, 16'h0001);
      end_of_test();
    end
  endtask

  // open and close the vector unlock window
  task automatic unlock_sel();
    wr(1, {2'h0, io_offset}, 8'h01);
    cyc(1);
    wr(0, data_offset, 8'h02);
  endtask

  // sleep-off timed sequence
  task automatic bod_seq();
    wr(0, data_offset, 8'h60);
    cyc(1);
    wr(0, data_offset, 8'h40);
  endtask

  initial begin
    cyc(3);
    rstn = 1'b1;
    cyc(1);
    chk("reset image", 16'h0000, 16'(rdata));
    chk("pullups", 16'h0044, 16'(pullup_en));
    chk("reset vector", 16'h0000, 16'(vector_addr));
    vnum = 6'h05;
    $display("test reset done");
    wr(1, {2'h0, io_offset}, 8'h10);
    cyc(2);
    chk("pullup off", 16'h0000, 16'(pullup_en));
    chk("io write", 16'h0010, 16'(rdata));
    chk("pullup bit", 16'h0001, 16'(puoff));
    wr(0, data_offset + 8'h01, 8'h00);
    cyc(2);
    chk("unmapped", 16'h0010, 16'(rdata));
    wr(0, data_offset, 8'h8c);
    cyc(2);
    chk("unused bits", 16'h0000, 16'(rdata));
    chk("pullup back", 16'h0044, 16'(pullup_en));
    $display("test access done");
    wr(0, data_offset, 8'h02);
    cyc(2);
    chk("select locked", 16'h0000, 16'(vsel));
    wr(0, data_offset, 8'h01);
    n = 0;
    m = 0;
    repeat (10) begin
      cyc(1);
      n += (irq_block === 1'b1);
      m += (rdata[0] === 1'b1);
    end
    chk("block cycles", 16'(unlock_cycles), 16'(n));
    chk("unlock cycles", 16'(unlock_cycles), 16'(m));
    wr(0, data_offset, 8'h02);
    cyc(2);
    chk("late select", 16'h0000, 16'(vsel));
    boot_lock = 1'b1;
    in_boot = 1'b1;
    cyc(2);
    chk("boot lock", 16'h0001, 16'(irq_block));
    in_boot = 1'b0;
    cyc(2);
    chk("app exec", 16'h0000, 16'(irq_block));
    boot_lock = 1'b0;
    chk("flash vector", 16'h000a, 16'(vector_addr));
    $display("test timeout done");
    unlock_sel();
    cyc(3);
    chk("select set", 16'h0001, 16'(vsel));
    chk("held block", 16'h0001, 16'(irq_block));
    chk("unlock gone", 16'h0002, 16'(rdata));
    step = 1'b1;
    for (i = 0; i < 20 && irq_block !== 1'b0; i++) cyc(1);
    guard(i);
    chk("boot vector", 16'h1c0a, 16'(vector_addr));
    app_lock = 1'b1;
    cyc(2);
    chk("app lock", 16'h0001, 16'(irq_block));
    in_boot = 1'b1;
    cyc(2);
    chk("boot exec", 16'h0000, 16'(irq_block));
    app_lock = 1'b0;
    in_boot = 1'b0;
    $display("test vector move done");
    wr(0, data_offset, 8'h40);
    n = 0;
    repeat (12) begin
      cyc(1);
      n += (rdata[6] === 1'b1);
    end
    chk("lone sleep-off", 16'h0000, 16'(n));
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    chk("sleep without off", 16'h0000, 16'(brownout_off));
    bod_seq();
    n = 0;
    repeat (12) begin
      cyc(1);
      n += (rdata[6] === 1'b1);
    end
    chk("active cycles", 16'(bod_delay_cycles), 16'(n));
    step = 1'b0;
    bod_seq();
    for (i = 0; i < 20 && rdata[6] !== 1'b1; i++) cyc(1);
    guard(i);
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    cyc(1);
    chk("detector off", 16'h0001, 16'(brownout_off));
    step = 1'b1;
    cyc(2);
    chk("detector on", 16'h0000, 16'(brownout_off));
    $display("test brownout done");
    end_of_test();
  end
endmodule
